// ==== core/tail_exec_pkg.sv ====
// Shared types and constants for the tail instruction executor.
// Assumes a 32-bit classic Wishbone register bus.
package tail_exec_pkg;

   // Register byte offsets
   localparam logic [8:0] OFF_ACC = 9'h000;
   localparam logic [8:0] OFF_FLAGS = 9'h004;
   localparam logic [8:0] OFF_TBL_PTR = 9'h008;
   localparam logic [8:0] OFF_TBL_HIGH = 9'h00c;
   localparam logic [8:0] OFF_CMD = 9'h010;
   localparam logic [8:0] OFF_EXEC = 9'h014;
   localparam int MEM_SEL_BIT = 8;

   // Execution status fields
   localparam int EXEC_BUSY_BIT = 0;
   localparam int EXEC_SKIP_BIT = 1;

   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] TBL_PTR_RST = 8'h00;
   localparam logic [31:0] CMD_RST = 32'h0000_0000;

   typedef enum logic [3:0] {
      op_nop = 4'h0,
      op_nibble_exchange_to_acc = 4'h1,
      op_skip_when_null = 4'h2,
      op_move_then_skip_null = 4'h3,
      op_skip_bit_clear = 4'h4,
      op_table_read_current_page = 4'h5,
      op_table_read_final_page = 4'h6,
      op_xor_acc_mem = 4'h7,
      op_xor_into_memory = 4'h8,
      op_xor_literal = 4'h9
   } op_t;

   // Command word: op [3:0], bit [6:4], addr [23:16], literal [31:24]
   typedef struct packed {
      logic [7:0] literal;
      logic [7:0] addr;
      logic [8:0] rsvd;
      logic [2:0] bitsel;
      op_t op;
   } cmd_t;

   // Status flags, carry in bit 0
   typedef struct packed {
      logic watchdog_expiry_bit;
      logic power_down_flag;
      logic sign_excess_bit;
      logic zero_bit;
      logic half_borrow_bit;
      logic carry_bit;
   } flags_t;

   localparam flags_t FLAGS_RST = 6'h00;

   typedef struct packed {
      logic [7:0] value;
      logic to_acc;
      logic to_mem;
      logic upd_zero;
      logic skip_take;
      logic is_table;
   } res_t;

   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_exec = 4'h2,
      st_dummy = 4'h4,
      st_table = 4'h8
   } state_t;

   function automatic logic is_null(input logic [7:0] v);
      return v == 8'h00;
   endfunction

endpackage

// ==== core/tail_exec_alu.sv ====
// Operand and result logic of the tail instructions.
// Pure combinational; the caller writes results back.
`timescale 1ns/1ps
`default_nettype none
module tail_exec_alu (
   input wire tail_exec_pkg::op_t op_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] mem_i,
   input wire logic [2:0] bitsel_i,
   input wire logic [7:0] literal_i,
   output tail_exec_pkg::res_t res_o
);
   import tail_exec_pkg::*;

   always_comb begin
      res_o = '0;
      case (op_i)
         op_nibble_exchange_to_acc: begin
            res_o.value = {mem_i[3:0], mem_i[7:4]}; // RQ1
            res_o.to_acc = 1'b1;
         end
         op_skip_when_null: begin
            res_o.skip_take = is_null(mem_i); // RQ2
         end
         op_move_then_skip_null: begin
            res_o.value = mem_i; // RQ3
            res_o.to_acc = 1'b1;
            res_o.skip_take = is_null(mem_i); // RQ3
         end
         op_skip_bit_clear: begin
            res_o.skip_take = ~mem_i[bitsel_i]; // RQ4
         end
         op_table_read_current_page, op_table_read_final_page: begin
            res_o.is_table = 1'b1;
         end
         op_xor_acc_mem: begin
            res_o.value = acc_i ^ mem_i; // RQ7
            res_o.to_acc = 1'b1;
            res_o.upd_zero = 1'b1;
         end
         op_xor_into_memory: begin
            res_o.value = acc_i ^ mem_i; // RQ8
            res_o.to_mem = 1'b1;
            res_o.upd_zero = 1'b1;
         end
         op_xor_literal: begin
            res_o.value = acc_i ^ literal_i; // RQ9
            res_o.to_acc = 1'b1;
            res_o.upd_zero = 1'b1;
         end
         default: begin
            res_o = '0;
         end
      endcase
   end
endmodule // tail_exec_alu
`default_nettype wire

// ==== core/tail_exec_core.sv ====
// Executor for the tail of the 8-bit instruction set, with
// accumulator, flags, table registers and data memory.
// Assumes classic Wishbone, a ROM answering in the same cycle.
// Function
// RQ1: Nibble exchange puts swapped nibbles of memory byte into accumulator.
// RQ2: Skip-when-null on zero byte drops prefetch, 2 cycles; else 1.
// RQ3: Move-then-skip copies byte to accumulator; skips likewise on zero.
// RQ4: Bit test skips with a dummy cycle when selected bit is clear.
// RQ5: Current-page table read: low byte to memory, high to table-high.
// RQ6: Last-page table read: same transfer from the final program page.
// RQ7: XOR accumulator with memory into accumulator; only zero flag changes.
// RQ8: XOR into memory writes result back; only zero flag changes.
// RQ9: XOR with literal into accumulator; only zero flag changes.
// RQ10: Zero flag set when 8-bit result is zero, else cleared.
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tail_exec_core #(
   parameter int DM_DEPTH = 64,
   parameter int PM_AW = 11,
   parameter int PM_DW = 14
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [PM_AW-9:0] pc_page_i,
   input wire logic [PM_DW-1:0] rom_data_i,
   output logic [PM_AW-1:0] rom_addr_o,
   output logic rom_rd_o,
   output logic skip_o,
   output logic done_o
);
   import tail_exec_pkg::*;

   localparam int DM_AW = $clog2(DM_DEPTH);

   logic [7:0] mem_q [DM_DEPTH];
   logic [7:0] acc_r, acc_nxt;
   flags_t flags_r, flags_nxt;
   logic [7:0] table_index_pointer_r, table_index_pointer_nxt;
   logic [PM_DW-9:0] table_upper_byte_reg_r, table_upper_byte_reg_nxt;
   cmd_t cmd_r, cmd_nxt;
   state_t state_r, state_nxt;
   logic last_skip_r, last_skip_nxt;
   logic skip_nxt, done_nxt, rom_rd_nxt;
   logic [PM_AW-1:0] rom_addr_nxt;
   logic mem_we;
   logic [DM_AW-1:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rd;
   res_t res;
   logic ack_nxt;
   logic [31:0] dat_nxt;
   logic req, rd_phase, wr_fire, idle, in_mem;
   logic [DM_AW-1:0] bus_idx;

   assign mem_rd = mem_q[cmd_r.addr[DM_AW-1:0]];
   assign idle = state_r == st_idle;
   assign req = wb_cyc_i & wb_stb_i;
   // Registered ack: data sampled on the edge that sees ack high
   assign rd_phase = req & ~wb_ack_o;
   assign wr_fire = req & wb_we_i & wb_ack_o & idle;
   assign bus_idx = wb_adr_i[DM_AW+1:2];
   assign in_mem = wb_adr_i[MEM_SEL_BIT] & (32'(bus_idx) < DM_DEPTH);

   tail_exec_alu u_alu (
      .op_i(cmd_r.op),
      .acc_i(acc_r),
      .mem_i(mem_rd),
      .bitsel_i(cmd_r.bitsel),
      .literal_i(cmd_r.literal),
      .res_o(res)
   );

   // Bus answer
   always_comb begin
      ack_nxt = rd_phase;
      dat_nxt = 32'h0000_0000;
      if (rd_phase & ~wb_we_i) begin
         if (wb_adr_i[MEM_SEL_BIT]) begin
            if (in_mem)
               dat_nxt = 32'(mem_q[bus_idx]);
         end else begin
            case (wb_adr_i)
               OFF_ACC: dat_nxt = 32'(acc_r);
               OFF_FLAGS: dat_nxt = 32'(flags_r);
               OFF_TBL_PTR: dat_nxt = 32'(table_index_pointer_r);
               OFF_TBL_HIGH: dat_nxt = 32'(table_upper_byte_reg_r);
               OFF_CMD: dat_nxt = cmd_r;
               OFF_EXEC: begin
                  dat_nxt[EXEC_BUSY_BIT] = ~idle;
                  dat_nxt[EXEC_SKIP_BIT] = last_skip_r;
               end
               default: dat_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= ack_nxt;
         wb_dat_o <= dat_nxt;
      end
   end

   // Execution sequence and register writes
   always_comb begin
      state_nxt = state_r;
      acc_nxt = acc_r;
      flags_nxt = flags_r;
      table_index_pointer_nxt = table_index_pointer_r;
      table_upper_byte_reg_nxt = table_upper_byte_reg_r;
      cmd_nxt = cmd_r;
      last_skip_nxt = last_skip_r;
      skip_nxt = 1'b0;
      done_nxt = 1'b0;
      rom_rd_nxt = 1'b0;
      rom_addr_nxt = rom_addr_o;
      mem_we = 1'b0;
      mem_waddr = cmd_r.addr[DM_AW-1:0];
      mem_wdata = res.value;
      case (state_r)
         st_idle: begin
            // Bus writes only land while idle
            if (wr_fire & wb_adr_i[MEM_SEL_BIT]) begin
               mem_we = in_mem & wb_sel_i[0];
               mem_waddr = bus_idx;
               mem_wdata = wb_dat_i[7:0];
            end else if (wr_fire) begin
               case (wb_adr_i)
                  OFF_ACC:
                     if (wb_sel_i[0]) acc_nxt = wb_dat_i[7:0];
                  OFF_FLAGS:
                     if (wb_sel_i[0]) flags_nxt = wb_dat_i[5:0];
                  OFF_TBL_PTR:
                     if (wb_sel_i[0]) table_index_pointer_nxt = wb_dat_i[7:0];
                  OFF_CMD:
                     if (wb_sel_i == 4'hf) begin
                        cmd_nxt = wb_dat_i;
                        state_nxt = st_exec;
                     end
                  default: state_nxt = st_idle;
               endcase
            end
         end
         st_exec: begin
            if (res.to_acc)
               acc_nxt = res.value; // RQ1 RQ3 RQ7 RQ9
            mem_we = res.to_mem; // RQ8
            if (res.upd_zero)
               flags_nxt.zero_bit = is_null(res.value); // RQ10
            last_skip_nxt = res.skip_take;
            if (res.is_table) begin
               rom_rd_nxt = 1'b1;
               if (cmd_r.op == op_table_read_final_page)
                  rom_addr_nxt = {{(PM_AW-8){1'b1}}, table_index_pointer_r}; // RQ6
               else
                  rom_addr_nxt = {pc_page_i, table_index_pointer_r}; // RQ5
               state_nxt = st_table;
            end else if (res.skip_take) begin
               skip_nxt = 1'b1; // RQ2 RQ3 RQ4
               state_nxt = st_dummy;
            end else begin
               done_nxt = 1'b1;
               state_nxt = st_idle;
            end
         end
         st_dummy: begin
            done_nxt = 1'b1;
            state_nxt = st_idle;
         end
         st_table: begin
            mem_we = 1'b1; // RQ5 RQ6
            mem_wdata = rom_data_i[7:0];
            table_upper_byte_reg_nxt = rom_data_i[PM_DW-1:8]; // RQ5 RQ6
            done_nxt = 1'b1;
            state_nxt = st_idle;
         end
         default: state_nxt = st_idle;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_r <= st_idle;
         acc_r <= ACC_RST;
         flags_r <= FLAGS_RST;
         table_index_pointer_r <= TBL_PTR_RST;
         table_upper_byte_reg_r <= '0;
         cmd_r <= CMD_RST;
         last_skip_r <= 1'b0;
         skip_o <= 1'b0;
         done_o <= 1'b0;
         rom_rd_o <= 1'b0;
         rom_addr_o <= '0;
      end else begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
         table_index_pointer_r <= table_index_pointer_nxt;
         table_upper_byte_reg_r <= table_upper_byte_reg_nxt;
         cmd_r <= cmd_nxt;
         last_skip_r <= last_skip_nxt;
         skip_o <= skip_nxt;
         done_o <= done_nxt;
         rom_rd_o <= rom_rd_nxt;
         rom_addr_o <= rom_addr_nxt;
      end
   end

   // Memory holds no reset; contents are software's job
   always_ff @(posedge clk_i) begin
      if (mem_we)
         mem_q[mem_waddr] <= mem_wdata;
   end

   // Checks
   logic exec_q;
   assign exec_q = state_r == st_exec;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   a_swap_to_acc: assert property ( // RQ1
      exec_q && cmd_r.op == op_nibble_exchange_to_acc
      |=> acc_r == {$past(mem_rd[3:0]), $past(mem_rd[7:4])} && flags_r == $past(flags_r))
      else $error("nibble exchange result wrong");

   a_null_skip_seq: assert property ( // RQ2
      exec_q && cmd_r.op == op_skip_when_null && is_null(mem_rd)
      |=> skip_o && state_r == st_dummy ##1 done_o && state_r == st_idle)
      else $error("null skip did not take two cycles");

   a_no_skip_short: assert property ( // RQ2
      exec_q && cmd_r.op == op_skip_when_null && !is_null(mem_rd)
      |=> !skip_o && done_o && state_r == st_idle)
      else $error("non-null skip test not one cycle");

   a_move_copies: assert property ( // RQ3
      exec_q && cmd_r.op == op_move_then_skip_null
      |=> acc_r == $past(mem_rd) && skip_o == is_null(acc_r) && flags_r == $past(flags_r))
      else $error("move then skip wrong");

   a_bit_skip: assert property ( // RQ4
      exec_q && cmd_r.op == op_skip_bit_clear
      |=> skip_o == !$past(mem_rd[cmd_r.bitsel]))
      else $error("bit skip decision wrong");

   a_table_current: assert property ( // RQ5
      exec_q && cmd_r.op == op_table_read_current_page
      |=> rom_rd_o && rom_addr_o == {$past(pc_page_i), table_index_pointer_r})
      else $error("current page table address wrong");

   a_table_final: assert property ( // RQ6
      exec_q && cmd_r.op == op_table_read_final_page
      |=> rom_rd_o && rom_addr_o[PM_AW-1:8] == '1 && rom_addr_o[7:0] == table_index_pointer_r)
      else $error("final page table address wrong");

   a_table_high: assert property ( // RQ5
      state_r == st_table
      |=> table_upper_byte_reg_r == $past(rom_data_i[PM_DW-1:8]) && done_o)
      else $error("table high byte not loaded");

   a_xor_acc: assert property ( // RQ7
      exec_q && cmd_r.op == op_xor_acc_mem
      |=> acc_r == ($past(acc_r) ^ $past(mem_rd))
          && {flags_r[5:3], flags_r[1:0]} == {$past(flags_r[5:3]), $past(flags_r[1:0])})
      else $error("xor into accumulator wrong");

   a_xor_mem: assert property ( // RQ8
      exec_q && cmd_r.op == op_xor_into_memory
      |=> mem_q[$past(cmd_r.addr[DM_AW-1:0])] == ($past(acc_r) ^ $past(mem_rd)))
      else $error("xor into memory wrong");

   a_xor_literal: assert property ( // RQ9
      exec_q && cmd_r.op == op_xor_literal
      |=> acc_r == ($past(acc_r) ^ $past(cmd_r.literal)))
      else $error("xor literal wrong");

   a_zero_flag: assert property ( // RQ10
      exec_q && res.upd_zero |=> flags_r.zero_bit == is_null($past(res.value)))
      else $error("zero flag wrong");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   c_null_skip: cover property (
      exec_q && cmd_r.op == op_skip_when_null ##1 skip_o);
   c_bit_no_skip: cover property (
      exec_q && cmd_r.op == op_skip_bit_clear ##1 !skip_o);
   c_table_final: cover property (
      exec_q && cmd_r.op == op_table_read_final_page ##2 done_o);
   c_xor_zero: cover property (
      exec_q && cmd_r.op == op_xor_literal && is_null(res.value));

endmodule // tail_exec_core
`default_nettype wire

// ==== verif/tb_tail_exec_core.sv ====
// Self-checking bench for the tail instruction executor.
// Drives Wishbone and a combinational program ROM; no partner model.
`timescale 1ns/1ps
`default_nettype none
module tb_tail_exec_core;
   import tail_exec_pkg::*;

   typedef struct packed {
      op_t op;
      logic [2:0] bs;
      logic [7:0] acc;
      logic [7:0] mem;
      logic [7:0] lit;
      logic [5:0] fi;
      logic [7:0] eacc;
      logic [7:0] emem;
      logic [5:0] ef;
      logic esk;
   } row_t;

   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [8:0] adr = 9'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [2:0] pc_page = 3'h0;
   logic [13:0] rom_data;
   logic [10:0] rom_addr_o;
   logic rom_rd_o;
   logic skip_o;
   logic done_o;
   int bad_count = 0;
   int n_compared = 0;
   row_t rows [0:14];

   // ROM word depends on every address bit, so a wrong page shows up
   assign rom_data = {~rom_addr_o[2:0], rom_addr_o};

   tail_exec_core dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_page_i(pc_page),
      .rom_data_i(rom_data), .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o),
      .skip_o(skip_o), .done_o(done_o)
   );

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Entered just after a rising edge; leaves one idle cycle behind
   task automatic wb_cycle(input logic w, input logic [8:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] q);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      q = wb_dat_o;
      if (k >= 50) check("ack wait", 32'h0000_0001, 32'h0000_0000);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, s, q);
   endtask

   task automatic rd_chk(input string name, input logic [8:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb_cycle(1'b0, a, 32'h0000_0000, 4'hF, q);
      check(name, e, q);
   endtask

   // Cycles from the idle edge after the command write to done_o
   task automatic exec(input cmd_t c, output int n, output logic sk, output logic [11:0] ra);
      n = 0;
      sk = 1'b0;
      ra = 12'h000;
      wr(OFF_CMD, c, 4'hF);
      do begin
         @(posedge clk_i);
         n++;
         if (skip_o === 1'b1) sk = 1'b1;
         if (rom_rd_o === 1'b1) ra = {1'b1, rom_addr_o};
      end while (done_o !== 1'b1 && n < 20);
   endtask

   function automatic logic [8:0] mad(input int i);
      return 9'h100 + 9'(4 * i);
   endfunction

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      conclude();
   end

   initial begin
      cmd_t c;
      int n;
      logic sk;
      logic [11:0] ra;
      logic [10:0] ea;
      logic [13:0] ew;
      rows[0] = '{op_nibble_exchange_to_acc, 3'h0, 8'h00, 8'hA5, 8'h00, 6'h3F, 8'h5A, 8'hA5, 6'h3F, 1'b0};
      rows[1] = '{op_nibble_exchange_to_acc, 3'h0, 8'hFF, 8'h00, 8'h00, 6'h3B, 8'h00, 8'h00, 6'h3B, 1'b0};
      rows[2] = '{op_skip_when_null, 3'h0, 8'h11, 8'h00, 8'h00, 6'h3B, 8'h11, 8'h00, 6'h3B, 1'b1};
      rows[3] = '{op_skip_when_null, 3'h0, 8'h11, 8'h80, 8'h00, 6'h04, 8'h11, 8'h80, 6'h04, 1'b0};
      rows[4] = '{op_move_then_skip_null, 3'h0, 8'h77, 8'h00, 8'h00, 6'h3B, 8'h00, 8'h00, 6'h3B, 1'b1};
      rows[5] = '{op_move_then_skip_null, 3'h0, 8'h77, 8'h01, 8'h00, 6'h04, 8'h01, 8'h01, 6'h04, 1'b0};
      rows[6] = '{op_skip_bit_clear, 3'h7, 8'h22, 8'h7F, 8'h00, 6'h3F, 8'h22, 8'h7F, 6'h3F, 1'b1};
      rows[7] = '{op_skip_bit_clear, 3'h0, 8'h22, 8'h01, 8'h00, 6'h00, 8'h22, 8'h01, 6'h00, 1'b0};
      rows[8] = '{op_skip_bit_clear, 3'h3, 8'h22, 8'hF7, 8'h00, 6'h00, 8'h22, 8'hF7, 6'h00, 1'b1};
      rows[9] = '{op_xor_acc_mem, 3'h0, 8'h5A, 8'h5A, 8'h00, 6'h3B, 8'h00, 8'h5A, 6'h3F, 1'b0};
      rows[10] = '{op_xor_acc_mem, 3'h0, 8'hF0, 8'h0F, 8'h00, 6'h3F, 8'hFF, 8'h0F, 6'h3B, 1'b0};
      rows[11] = '{op_xor_into_memory, 3'h0, 8'h3C, 8'hC3, 8'h00, 6'h04, 8'h3C, 8'hFF, 6'h00, 1'b0};
      rows[12] = '{op_xor_into_memory, 3'h0, 8'h81, 8'h81, 8'h00, 6'h3B, 8'h81, 8'h00, 6'h3F, 1'b0};
      rows[13] = '{op_xor_literal, 3'h0, 8'h55, 8'h99, 8'h55, 6'h3B, 8'h00, 8'h99, 6'h3F, 1'b0};
      rows[14] = '{op_xor_literal, 3'h0, 8'h12, 8'h99, 8'h34, 6'h3F, 8'h26, 8'h99, 6'h3B, 1'b0};
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rd_chk("acc rst", OFF_ACC, 32'h0000_0000);
      rd_chk("flags rst", OFF_FLAGS, 32'h0000_0000);
      rd_chk("pointer rst", OFF_TBL_PTR, 32'h0000_0000);
      rd_chk("table high rst", OFF_TBL_HIGH, 32'h0000_0000);
      rd_chk("cmd rst", OFF_CMD, 32'h0000_0000);
      rd_chk("exec rst", OFF_EXEC, 32'h0000_0000);
      for (int i = 0; i < 15; i++) begin
         wr(OFF_ACC, 32'(rows[i].acc), 4'hF);
         wr(mad(i * 3), 32'(rows[i].mem), 4'hF);
         wr(OFF_FLAGS, 32'(rows[i].fi), 4'hF);
         c = cmd_t'(32'h0000_0000);
         c.op = rows[i].op;
         c.bitsel = rows[i].bs;
         c.addr = 8'(i * 3);
         c.literal = rows[i].lit;
         exec(c, n, sk, ra);
         check("skip", 32'(rows[i].esk), 32'(sk));
         check("cycles", rows[i].esk ? 32'h0000_0002 : 32'h0000_0001, 32'(n));
         rd_chk("acc", OFF_ACC, 32'(rows[i].eacc));
         rd_chk("mem", mad(i * 3), 32'(rows[i].emem));
         rd_chk("flags", OFF_FLAGS, 32'(rows[i].ef));
         rd_chk("exec skip", OFF_EXEC, 32'(rows[i].esk) << EXEC_SKIP_BIT);
      end
      // Table reads, current page then final page, pointer at 9C then FF
      pc_page <= 3'h5;
      for (int t = 0; t < 2; t++) begin
         wr(OFF_TBL_PTR, t ? 32'h0000_00FF : 32'h0000_009C, 4'hF);
         wr(OFF_FLAGS, 32'h0000_002A, 4'hF);
         ea = t ? 11'h7FF : 11'h59C;
         ew = {~ea[2:0], ea};
         c = cmd_t'(32'h0000_0000);
         c.op = t ? op_table_read_final_page : op_table_read_current_page;
         c.addr = 8'h3F;
         exec(c, n, sk, ra);
         check("rom addr", 32'({1'b1, ea}), 32'(ra));
         check("tbl cycles", 32'h0000_0002, 32'(n));
         rd_chk("tbl low", mad(63), 32'(ew[7:0]));
         rd_chk("tbl high", OFF_TBL_HIGH, 32'(ew[13:8]));
         rd_chk("tbl flags", OFF_FLAGS, 32'h0000_002A);
      end
      // Refused accesses
      wr(OFF_ACC, 32'h0000_00C7, 4'hF);
      wr(OFF_ACC, 32'h0000_0011, 4'h2);
      rd_chk("acc sel", OFF_ACC, 32'h0000_00C7);
      wr(OFF_TBL_HIGH, 32'h0000_0000, 4'hF);
      rd_chk("table high ro", OFF_TBL_HIGH, 32'(ew[13:8]));
      wr(9'h018, 32'hFFFF_FFFF, 4'hF);
      rd_chk("unmapped", 9'h018, 32'h0000_0000);
      wr(OFF_CMD, 32'h5A00_0009, 4'h7);
      rd_chk("acc cmd sel", OFF_ACC, 32'h0000_00C7);
      rd_chk("cmd keep", OFF_CMD, 32'h003F_0006);
      // Busy seen from the bus during the dummy cycle of a taken skip
      wr(OFF_CMD, 32'h0003_0002, 4'hF);
      rd_chk("exec busy", OFF_EXEC, 32'h0000_0003);
      // Second reset in mid-run
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rd_chk("acc rst2", OFF_ACC, 32'h0000_0000);
      rd_chk("table high rst2", OFF_TBL_HIGH, 32'h0000_0000);
      conclude();
   end
endmodule // tb_tail_exec_core
`default_nettype wire
